// *** srap_pkg.sv ***
// Purpose: Shared constants for the serial register access port, both ends.
// Assumes: Serial clock sampled by a 50 MHz system clock.
// Notes: Frame is 5-bit instruction, 11-bit address, 8-bit data, MSB first.
package srap_pkg;
  localparam int SRAP_INSTR_BITS = 5;
  localparam int SRAP_ADDR_BITS = 11;
  localparam int SRAP_DATA_BITS = 8;
  localparam int SRAP_HDR_BITS = SRAP_INSTR_BITS + SRAP_ADDR_BITS;
  localparam int SRAP_FRAME_BITS = SRAP_HDR_BITS + SRAP_DATA_BITS;
  localparam logic SRAP_OP_READ = 1'b1;
  localparam logic SRAP_OP_WRITE = 1'b0;
  localparam int SRAP_CLK_SYS_MHZ = 50;
  // Serial clock half period; 205 ns least high and low time.
  localparam int SRAP_CLK_HALF_NS = 240;
  localparam int SRAP_CLK_HALF_CYC = (SRAP_CLK_HALF_NS * SRAP_CLK_SYS_MHZ + 999) / 1000;
  // Select setup, hold and high time, 100 ns covers all three.
  localparam int SRAP_CS_GAP_NS = 100;
  localparam int SRAP_CS_GAP_CYC = (SRAP_CS_GAP_NS * SRAP_CLK_SYS_MHZ + 999) / 1000;
  localparam int SRAP_CNT_W = 8;
  localparam int SRAP_BIT_W = 5;
endpackage

// *** srap_link_if.sv ***
// Purpose: Serial link between host and device ends.
// Assumes: The output line is resolved here from its enable, idling high as if pulled up.
// Notes: No clocking block.
`timescale 1ns/1ps
interface srap_link_if;
  logic chipSelectN;
  logic serialClockPin;
  logic serialInLine;
  logic serialOutLineO;
  logic serialOutLineOe;
  logic serialOutLine;
  assign serialOutLine = serialOutLineOe ? serialOutLineO : 1'b1;
  modport device (input chipSelectN, input serialClockPin, input serialInLine,
    output serialOutLineO, output serialOutLineOe);
  modport host (output chipSelectN, output serialClockPin, output serialInLine,
    input serialOutLine);
endinterface

// *** srap_device.sv ***
// What this block does
// - Select falling starts, rising ends a transaction.
// - Five instruction bits sampled on serial rising.
// - Instruction top bit one reads, zero writes.
// - Eleven address bits follow the instruction.
// - Read data shifted out on serial falling.
// - Write data follows address, stored in register.
// Purpose: Device end; register array reached through the serial link.
// Assumes: Link pins are asynchronous and pass two flip-flops first.
// Notes: Output line changes on falling serial edges and is released on select rising.
`timescale 1ns/1ps
module srap_device
  import srap_pkg::*;
#(
  parameter int NUM_REGS = 2048
) (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  srap_link_if.device link,
  // User side
  output logic wrStrobe_r,
  output logic [SRAP_ADDR_BITS-1:0] wrAddr_r,
  output logic [SRAP_DATA_BITS-1:0] wrData_r
);
  // Link pins arrive from another clock domain; each passes two flops first.
  logic [1:0] csSync_r;
  logic [1:0] sckSync_r;
  logic [1:0] sdiSync_r;
  logic csPrev_r;
  logic sckPrev_r;
  // Frame progress and receive shifting.
  logic active_r;
  logic [SRAP_BIT_W-1:0] bitCnt_r;
  logic [SRAP_HDR_BITS-1:0] hdr_r;
  logic [SRAP_DATA_BITS-1:0] shIn_r;
  logic isRead_r;
  // Read side.
  logic [SRAP_DATA_BITS-1:0] shOut_r;
  logic sdo_r;
  logic sdoOe_r;
  // Register storage, one byte per address.
  logic [SRAP_DATA_BITS-1:0] regs [NUM_REGS];
  // Decoded events, all on the system clock.
  logic csFall;
  logic csRise;
  logic sckRise;
  logic sckFall;
  logic bitTake;
  logic lastBit;
  logic loadOut;
  logic shiftOut;

  // Register address held in the low bits of the header.
  function automatic logic [SRAP_ADDR_BITS-1:0] hdrAddr(input logic [SRAP_HDR_BITS-1:0] hdr);
    return hdr[SRAP_ADDR_BITS-1:0];
  endfunction

  // One more data bit shifted in at the bottom, so the first bit ends at the top.
  function automatic logic [SRAP_DATA_BITS-1:0] dataShift(input logic [SRAP_DATA_BITS-1:0] sr,
      input logic b);
    return {sr[SRAP_DATA_BITS-2:0], b};
  endfunction

  // True when the bit counter stands at the given frame position.
  function automatic logic atBit(input logic [SRAP_BIT_W-1:0] cnt, input int pos);
    return cnt == SRAP_BIT_W'(pos);
  endfunction

  // Select synchroniser resets to the deselected level, so no false edge follows reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      csSync_r <= 2'b11;
      csPrev_r <= 1'b1;
    end else begin
      csSync_r <= {csSync_r[0], link.chipSelectN};
      csPrev_r <= csSync_r[1];
    end
  end

  // Serial clock synchroniser; the clock idles low between frames.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sckSync_r <= 2'b00;
      sckPrev_r <= 1'b0;
    end else begin
      sckSync_r <= {sckSync_r[0], link.serialClockPin};
      sckPrev_r <= sckSync_r[1];
    end
  end

  // Same depth as the clock path, so the setup seen on the pins is kept.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdiSync_r <= 2'b00;
    end else begin
      sdiSync_r <= {sdiSync_r[0], link.serialInLine};
    end
  end

  assign csFall = csPrev_r && !csSync_r[1];
  assign csRise = !csPrev_r && csSync_r[1];
  // Serial edges outside a frame are ignored, so a free-running clock does no harm.
  assign sckRise = !sckPrev_r && sckSync_r[1] && !csSync_r[1];
  assign sckFall = sckPrev_r && !sckSync_r[1] && !csSync_r[1];
  // Bits after the last frame bit are ignored.
  assign bitTake = active_r && sckRise && (bitCnt_r < SRAP_BIT_W'(SRAP_FRAME_BITS));
  assign lastBit = atBit(bitCnt_r, SRAP_FRAME_BITS - 1);
  assign loadOut = isRead_r && sckFall && atBit(bitCnt_r, SRAP_HDR_BITS);
  // The final falling edge leaves the line alone; no bit is shifted past the byte.
  assign shiftOut = isRead_r && sckFall && (bitCnt_r > SRAP_BIT_W'(SRAP_HDR_BITS))
      && (bitCnt_r < SRAP_BIT_W'(SRAP_FRAME_BITS));

  // Frame is open from select falling to select rising.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      active_r <= 1'b0;
    end else if (csFall) begin
      active_r <= 1'b1;
    end else if (csRise) begin
      active_r <= 1'b0;
    end
  end

  // Bit counter restarts with every frame, so a cut frame leaves nothing behind.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitCnt_r <= '0;
    end else if (csFall) begin
      bitCnt_r <= '0;
    end else if (bitTake) begin
      bitCnt_r <= bitCnt_r + 1'b1;
    end
  end

  // Instruction and address bits.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hdr_r <= '0;
    end else if (bitTake && (bitCnt_r < SRAP_BIT_W'(SRAP_HDR_BITS))) begin
      hdr_r <= {hdr_r[SRAP_HDR_BITS-2:0], sdiSync_r[1]};
    end
  end

  // Direction is fixed by the first bit; the other instruction bits are ignored.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      isRead_r <= 1'b0;
    end else if (bitTake && atBit(bitCnt_r, 0)) begin
      isRead_r <= (sdiSync_r[1] == SRAP_OP_READ);
    end
  end

  // Data bits; on a read they are shifted in too but never used.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shIn_r <= '0;
    end else if (bitTake && (bitCnt_r >= SRAP_BIT_W'(SRAP_HDR_BITS))) begin
      shIn_r <= dataShift(shIn_r, sdiSync_r[1]);
    end
  end

  // Write commit on the last data bit, while the address is known. A frame cut short
  // never reaches the last bit, so it stores nothing.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrStrobe_r <= 1'b0;
      wrAddr_r <= '0;
      wrData_r <= '0;
    end else begin
      wrStrobe_r <= 1'b0;
      if (bitTake && !isRead_r && lastBit) begin
        wrStrobe_r <= 1'b1;
        wrAddr_r <= hdrAddr(hdr_r);
        wrData_r <= dataShift(shIn_r, sdiSync_r[1]);
      end
    end
  end

  // Register storage has no reset, as a RAM would.
  always_ff @(posedge clk_sys) begin
    if (wrStrobe_r) begin
      regs[wrAddr_r] <= wrData_r;
    end
  end

  // Output enable is on from the first read data bit until the frame closes.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdoOe_r <= 1'b0;
    end else if (!active_r || csRise) begin
      sdoOe_r <= 1'b0;
    end else if (loadOut) begin
      sdoOe_r <= 1'b1;
    end
  end

  // Read data is loaded once the header is complete, then moved on falling serial edges.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shOut_r <= '0;
      sdo_r <= 1'b0;
    end else if (!active_r || csRise) begin
      sdo_r <= 1'b0;
    end else if (loadOut) begin
      sdo_r <= regs[hdrAddr(hdr_r)][SRAP_DATA_BITS-1];
      shOut_r <= regs[hdrAddr(hdr_r)] << 1;
    end else if (shiftOut) begin
      sdo_r <= shOut_r[SRAP_DATA_BITS-1];
      shOut_r <= shOut_r << 1;
    end
  end

  assign link.serialOutLineO = sdo_r;
  assign link.serialOutLineOe = sdoOe_r;
endmodule

// *** srap_host.sv ***
// Purpose: Host end; issues one read or write per request over the link.
// Assumes: Serial clock made here by dividing clk_sys.
// Notes: Read data is taken on the serial rising edge.
`timescale 1ns/1ps
module srap_host
  import srap_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Request
  input wire logic reqValid,
  input wire logic reqRead,
  input wire logic [SRAP_ADDR_BITS-1:0] reqAddr,
  input wire logic [SRAP_DATA_BITS-1:0] reqData,
  output logic busy_r,
  output logic done_r,
  output logic [SRAP_DATA_BITS-1:0] rdData_r,
  // Link
  srap_link_if.host link
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_SETUP = 4'b0010, ST_SHIFT = 4'b0100, ST_HOLD = 4'b1000
  } srap_state_t;
  srap_state_t state_r;
  logic [SRAP_CNT_W-1:0] tick_r;
  logic [SRAP_BIT_W-1:0] bitCnt_r;
  logic [SRAP_FRAME_BITS-1:0] frame_r;
  logic [1:0] sdoSync_r;
  logic cs_r, sck_r, sdi_r, isRead_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sdoSync_r <= 2'b11;
    end else begin
      sdoSync_r <= {sdoSync_r[0], link.serialOutLine};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      tick_r <= '0;
      bitCnt_r <= '0;
      frame_r <= '0;
      cs_r <= 1'b1;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
      isRead_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdData_r <= '0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (reqValid && tick_r == '0) begin
            cs_r <= 1'b0;
            busy_r <= 1'b1;
            isRead_r <= reqRead;
            // Instruction top bit picks the direction; the rest are zero.
            frame_r <= {reqRead ? SRAP_OP_READ : SRAP_OP_WRITE,
                        (SRAP_INSTR_BITS - 1)'(0), reqAddr, reqData};
            tick_r <= SRAP_CNT_W'(SRAP_CS_GAP_CYC);
            bitCnt_r <= '0;
            state_r <= ST_SETUP;
          end else if (tick_r != '0) begin
            tick_r <= tick_r - 1'b1;
          end
        end
        ST_SETUP: begin
          if (tick_r == '0) begin
            sdi_r <= frame_r[SRAP_FRAME_BITS-1];
            tick_r <= SRAP_CNT_W'(SRAP_CLK_HALF_CYC);
            state_r <= ST_SHIFT;
          end else begin
            tick_r <= tick_r - 1'b1;
          end
        end
        ST_SHIFT: begin
          if (tick_r != '0) begin
            tick_r <= tick_r - 1'b1;
          end else if (!sck_r) begin
            sck_r <= 1'b1;
            tick_r <= SRAP_CNT_W'(SRAP_CLK_HALF_CYC);
            if (isRead_r && bitCnt_r >= SRAP_BIT_W'(SRAP_HDR_BITS)) begin
              rdData_r <= {rdData_r[SRAP_DATA_BITS-2:0], sdoSync_r[1]};
            end
          end else begin
            sck_r <= 1'b0;
            frame_r <= frame_r << 1;
            sdi_r <= frame_r[SRAP_FRAME_BITS-2];
            tick_r <= SRAP_CNT_W'(SRAP_CLK_HALF_CYC);
            bitCnt_r <= bitCnt_r + 1'b1;
            if (bitCnt_r == SRAP_BIT_W'(SRAP_FRAME_BITS - 1)) begin
              tick_r <= SRAP_CNT_W'(SRAP_CS_GAP_CYC);
              state_r <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (tick_r == '0) begin
            cs_r <= 1'b1;
            busy_r <= 1'b0;
            done_r <= 1'b1;
            tick_r <= SRAP_CNT_W'(SRAP_CS_GAP_CYC);
            state_r <= ST_IDLE;
          end else begin
            tick_r <= tick_r - 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.chipSelectN = cs_r;
  assign link.serialClockPin = sck_r;
  assign link.serialInLine = sdi_r;
endmodule

// *** srap_link_chk.sv ***
// Purpose: Assertions on the link between host and device ends.
// Assumes: All link signals sampled on clk_sys.
// Notes: Serial half period is 13 system cycles.
`timescale 1ns/1ps
module srap_link_chk (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // Link
  input wire logic chipSelectN,
  input wire logic serialClockPin,
  input wire logic serialInLine,
  input wire logic serialOutLineO,
  input wire logic serialOutLineOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_CS_GAP: assert property ($rose(chipSelectN) |=> chipSelectN [*4])
    else $error("select high time short");
  AST_SCK_IDLE: assert property (chipSelectN |-> !serialClockPin)
    else $error("serial clock outside frame");
  AST_SCK_HIGH: assert property ($rose(serialClockPin) |-> serialClockPin [*8] ##1 serialClockPin [*3])
    else $error("serial clock high time short");
  AST_IN_STABLE: assert property (serialClockPin |-> $stable(serialInLine))
    else $error("input line moved while clock high");
  AST_OE_RELEASE: assert property ($rose(chipSelectN) |-> ##[0:4] !serialOutLineOe)
    else $error("output not released");
  AST_OE_IDLE: assert property (chipSelectN [*5] |-> !serialOutLineOe)
    else $error("output driven while deselected");
  AST_OUT_ON_LOW: assert property (serialOutLineOe && $past(serialOutLineOe) && $changed(serialOutLineO) |-> !serialClockPin)
    else $error("output changed while clock high");
  AST_OE_START: assert property ($rose(serialOutLineOe) |-> !chipSelectN && !serialClockPin)
    else $error("output enabled at wrong moment");
  cover property ($rose(serialOutLineOe));
  cover property ($rose(chipSelectN));
  cover property (serialClockPin [*8]);
endmodule

// *** tb_serial_register_access_port.sv ***
// Purpose: Reads and writes through the host end; checks wire and user sides.
// Assumes: Device registers are written before they are read.
// Notes: Expected bit count uses the package widths; the expected header and write bits use fixed literal widths.
`timescale 1ns/1ps
module tb_serial_register_access_port import srap_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqRead = 1'b0;
  logic [SRAP_ADDR_BITS-1:0] reqAddr = 11'h000;
  logic [SRAP_DATA_BITS-1:0] reqData = 8'h00;
  logic busy_r, done_r, wrStrobe_r, oeSeen;
  logic [SRAP_DATA_BITS-1:0] rdData_r, wrData_r, outSr;
  logic [SRAP_ADDR_BITS-1:0] wrAddr_r;
  logic [SRAP_FRAME_BITS-1:0] frameSr;
  logic [10:0] addrs [3] = '{11'h000, 11'h7ff, 11'h123};
  logic [7:0] datas [3] = '{8'ha5, 8'h3c, 8'h81};
  int bitCnt = 0;
  int strobeCnt = 0;
  int failures = 0;
  int n_tests = 0;
  srap_link_if link ();
  srap_host i_srap_host (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid),
    .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData), .busy_r(busy_r),
    .done_r(done_r), .rdData_r(rdData_r), .link(link.host));
  srap_device i_srap_device (.clk_sys(clk_sys), .rst(rst), .link(link.device),
    .wrStrobe_r(wrStrobe_r), .wrAddr_r(wrAddr_r), .wrData_r(wrData_r));
  srap_link_chk i_srap_link_chk (.clk_sys(clk_sys), .rst(rst),
    .chipSelectN(link.chipSelectN), .serialClockPin(link.serialClockPin),
    .serialInLine(link.serialInLine), .serialOutLineO(link.serialOutLineO),
    .serialOutLineOe(link.serialOutLineOe));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Wire watcher, restarted by every frame start.
  always @(negedge link.chipSelectN) begin
    bitCnt = 0;
    oeSeen = 1'b0;
  end
  always @(posedge link.serialClockPin) begin
    if (!link.chipSelectN) begin
      frameSr = {frameSr[SRAP_FRAME_BITS-2:0], link.serialInLine};
      outSr = {outSr[SRAP_DATA_BITS-2:0], link.serialOutLine};
      bitCnt++;
    end
  end
  always @(posedge clk_sys) begin
    if (link.serialOutLineOe === 1'b1) oeSeen = 1'b1;
    if (wrStrobe_r === 1'b1) strobeCnt++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic level);
    int k;
    k = 0;
    while (busy_r !== level) begin
      @(posedge clk_sys);
      k++;
      if (k > 2000) begin
        failures++;
        finish_test();
      end
    end
  endtask
  task automatic xfer(input logic rd, input logic [10:0] addr, input logic [7:0] data);
    int s0;
    s0 = strobeCnt;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= addr;
    reqData <= data;
    wait_busy(1'b1);
    reqValid <= 1'b0;
    wait_busy(1'b0);
    check("done pulse", done_r, 1'b1);
    check("bit count", bitCnt, SRAP_FRAME_BITS);
    check("header", frameSr[23:8], {rd, 4'h0, addr});
    if (rd) begin
      check("read data", rdData_r, data);
      check("line data", outSr, data);
      check("read drives", oeSeen, 1'b1);
    end else begin
      check("write bits", frameSr[7:0], data);
      check("strobes", strobeCnt - s0, 32'h1);
      check("wr addr", wrAddr_r, addr);
      check("wr data", wrData_r, data);
      check("write silent", oeSeen, 1'b0);
    end
    repeat (5) @(posedge clk_sys);
    check("select idle", link.chipSelectN, 1'b1);
    check("done ends", done_r, 1'b0);
    check("released", link.serialOutLineOe, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      xfer(i >= 3, addrs[i < 3 ? i : 5 - i], datas[i < 3 ? i : 5 - i]);
    end
    finish_test();
  end
endmodule
